// ---- common/fog_defines.svh ----
`ifndef FOG_DEFINES_SVH
`define FOG_DEFINES_SVH

// Register byte offsets
`define FOG_OFS_CTRL 5'h00
`define FOG_OFS_DUTY 5'h04
`define FOG_OFS_STAT 5'h08
`define FOG_OFS_CLR 5'h0c
`define FOG_OFS_EN 5'h10
`define FOG_OFS_LVL 5'h14

// Control register fields
`define FOG_CTRL_P2_LSB 0
`define FOG_CTRL_P3_LSB 3
`define FOG_CTRL_FO_ON 6
`define FOG_CTRL_W 7

// Reset values
`define FOG_CTRL_RST 7'h00
`define FOG_DUTY_RST 2'h0
`define FOG_STAT_RST 2'h0

// Timing
`define FOG_CLK_MHZ 10
`define FOG_BLINK_PERIOD_US 800000
`define FOG_PWM_PERIOD_US 10000
`define FOG_TEST_FILT_US 64
`define FOG_BLINK_CYC (`FOG_BLINK_PERIOD_US * `FOG_CLK_MHZ)
`define FOG_PWM_CYC (`FOG_PWM_PERIOD_US * `FOG_CLK_MHZ)
`define FOG_FILT_CYC (`FOG_TEST_FILT_US * `FOG_CLK_MHZ)
`define FOG_BLINK_W 23
`define FOG_PWM_W 17
`define FOG_FILT_W 10

`endif

// ---- common/fog_pkg.sv ----
package fog_pkg;

    typedef enum logic [2:0] {
        FOG_MODE_INIT = 3'h0,
        FOG_MODE_NORMAL = 3'h1,
        FOG_MODE_STOP = 3'h3,
        FOG_MODE_SLEEP = 3'h2,
        FOG_MODE_RESTART = 3'h6,
        FOG_MODE_FAILSAFE = 3'h7
    } fog_mode_e;

    typedef enum logic [2:0] {
        FOG_ROLE_FO = 3'h0,
        FOG_ROLE_OFF = 3'h1,
        FOG_ROLE_WAKE = 3'h2,
        FOG_ROLE_LS = 3'h3,
        FOG_ROLE_HS = 3'h4
    } fog_role_e;

endpackage : fog_pkg

// ---- rtl/fog_fail_gpio.sv ----
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "fog_defines.svh"

// Summary of operation
// - Both pins default to fail output role
// - Role per pin from writable control register
// - Wake role detects edges, latches status
// - Switches current limited in pad, no flags
// - First pin level reported in normal and stop, in wake or switch role
// - Second pin level bit is test level
// - Role writes only in normal mode
// - Wake capable in restart, off in failsafe
// - Switches off in restart and failsafe
// - Active fail output survives restart, config kept
// - Blink output 1.25 Hz, 50 percent
// - Pulsed output 100 Hz, duty adjustable
// - Test input filtered for 64 us
// - Three fail outputs assert together
// - Duty select 20, 10, 5, 2.5 percent
module fog_fail_gpio #(
    parameter int BLINK_CYC = `FOG_BLINK_CYC,
    parameter int PWM_CYC = `FOG_PWM_CYC
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire fog_pkg::fog_mode_e SBC_MODE,
    input wire logic FAIL_IN,
    output logic STATIC_FAIL_PIN_O,
    output logic STATIC_FAIL_PIN_OE_N,
    input wire logic BLINK_FAIL_PIN_I,
    output logic BLINK_FAIL_PIN_O,
    output logic BLINK_FAIL_PIN_OE_N,
    input wire logic PULSED_FAIL_TEST_PIN_I,
    output logic PULSED_FAIL_TEST_PIN_O,
    output logic PULSED_FAIL_TEST_PIN_OE_N,
    output logic TEST_LEVEL,
    output logic IRQ
);

    localparam int BLINK_HALF = BLINK_CYC / 2;

    // Drive for one shared pin: {oe_n, out}
    function automatic logic [1:0] pin_drive(
        input fog_pkg::fog_role_e role,
        input fog_pkg::fog_mode_e mode,
        input logic fail_low
    );
        logic sw_on;
        sw_on = (mode == fog_pkg::FOG_MODE_NORMAL) || (mode == fog_pkg::FOG_MODE_STOP)
            || (mode == fog_pkg::FOG_MODE_SLEEP);
        pin_drive = 2'h2;
        case (role)
            fog_pkg::FOG_ROLE_FO: pin_drive = {~fail_low, 1'b0};
            fog_pkg::FOG_ROLE_LS: pin_drive = {~sw_on, 1'b0};
            fog_pkg::FOG_ROLE_HS: pin_drive = {~sw_on, sw_on};
            default: pin_drive = 2'h2;
        endcase
    endfunction : pin_drive

    function automatic logic wake_cap(
        input fog_pkg::fog_role_e role,
        input fog_pkg::fog_mode_e mode
    );
        wake_cap = (role == fog_pkg::FOG_ROLE_WAKE) && (mode != fog_pkg::FOG_MODE_FAILSAFE)
            && (mode != fog_pkg::FOG_MODE_INIT);
    endfunction : wake_cap

    function automatic logic gp_role(input fog_pkg::fog_role_e role);
        gp_role = (role == fog_pkg::FOG_ROLE_WAKE) || (role == fog_pkg::FOG_ROLE_LS)
            || (role == fog_pkg::FOG_ROLE_HS);
    endfunction : gp_role

    logic [`FOG_CTRL_W-1:0] ctrl;
    logic [1:0] duty;
    logic [1:0] stat;
    logic [1:0] en;
    logic [1:0] lvl;
    logic ack;
    logic fail_q;
    logic [`FOG_BLINK_W-1:0] blink_cnt;
    logic [`FOG_PWM_W-1:0] pwm_cnt;
    logic [`FOG_FILT_W-1:0] filt_cnt;
    logic test_flt;
    logic p2_q;
    logic p3_q;

    // Bus decode
    wire req = AVS_READ | AVS_WRITE;
    wire wr_en = AVS_WRITE & ack & AVS_BYTEENABLE[0];
    wire sel_ctrl = AVS_ADDRESS == `FOG_OFS_CTRL;
    wire sel_duty = AVS_ADDRESS == `FOG_OFS_DUTY;
    wire sel_stat = AVS_ADDRESS == `FOG_OFS_STAT;
    wire sel_clr = AVS_ADDRESS == `FOG_OFS_CLR;
    wire sel_en = AVS_ADDRESS == `FOG_OFS_EN;
    wire sel_lvl = AVS_ADDRESS == `FOG_OFS_LVL;
    wire is_normal = SBC_MODE == fog_pkg::FOG_MODE_NORMAL;
    wire cfg_wr = wr_en & is_normal;
    wire [31:0] rd_mux =
        sel_ctrl ? {25'h0, ctrl} :
        sel_duty ? {30'h0, duty} :
        sel_stat ? {30'h0, stat} :
        sel_en ? {30'h0, en} :
        sel_lvl ? {30'h0, lvl} :
        32'h0;

    assign AVS_WAITREQUEST = req & ~ack;

    // Role fields
    wire fog_pkg::fog_role_e role2 =
        fog_pkg::fog_role_e'(ctrl[`FOG_CTRL_P2_LSB +: 3]);
    wire fog_pkg::fog_role_e role3 =
        fog_pkg::fog_role_e'(ctrl[`FOG_CTRL_P3_LSB +: 3]);
    wire fo_on = ctrl[`FOG_CTRL_FO_ON];

    // Fail waveforms; active phase comes first
    wire fail_on = FAIL_IN | fo_on;
    wire fail_rise = fail_on & ~fail_q;
    wire [`FOG_PWM_W-1:0] pwm_on =
        (duty == 2'h0) ? `FOG_PWM_W'(PWM_CYC / 5) :
        (duty == 2'h1) ? `FOG_PWM_W'(PWM_CYC / 10) :
        (duty == 2'h2) ? `FOG_PWM_W'(PWM_CYC / 20) :
        `FOG_PWM_W'(PWM_CYC / 40);
    wire blink_low = fail_on & (blink_cnt < `FOG_BLINK_W'(BLINK_HALF));
    wire pwm_low = fail_on & (pwm_cnt < pwm_on);
    wire blink_end = blink_cnt == `FOG_BLINK_W'(BLINK_CYC - 1);
    wire pwm_end = pwm_cnt == `FOG_PWM_W'(PWM_CYC - 1);

    wire [1:0] drv2 = pin_drive(role2, SBC_MODE, blink_low);
    wire [1:0] drv3 = pin_drive(role3, SBC_MODE, pwm_low);

    // Levels and wake events
    wire lvl3_raw = PULSED_FAIL_TEST_PIN_I;
    wire filt_hit = filt_cnt == `FOG_FILT_W'(`FOG_FILT_CYC - 1);
    wire p2_lvl = BLINK_FAIL_PIN_I;
    wire wake2 = wake_cap(role2, SBC_MODE) & (p2_lvl != p2_q);
    wire wake3 = wake_cap(role3, SBC_MODE) & (test_flt != p3_q);
    wire show_lvl = is_normal | (SBC_MODE == fog_pkg::FOG_MODE_STOP);
    wire lvl2_upd = show_lvl & gp_role(role2);
    wire [1:0] clr_bits = (AVS_WRITE & ack & sel_clr & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[1:0] : 2'h0;
    wire [1:0] next_stat = (stat & ~clr_bits) | {wake3, wake2};

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ack <= 1'b0;
            AVS_READDATA <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (req & ~ack) begin
                AVS_READDATA <= AVS_READ ? rd_mux : 32'h0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ctrl <= `FOG_CTRL_RST;
            duty <= `FOG_DUTY_RST;
            en <= 2'h0;
        end else begin
            if (cfg_wr & sel_ctrl) begin
                ctrl <= AVS_WRITEDATA[`FOG_CTRL_W-1:0];
            end
            if (cfg_wr & sel_duty) begin
                duty <= AVS_WRITEDATA[1:0];
            end
            if (wr_en & sel_en) begin
                en <= AVS_WRITEDATA[1:0];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            stat <= `FOG_STAT_RST;
            IRQ <= 1'b0;
        end else begin
            stat <= next_stat;
            IRQ <= |(next_stat & en);
        end
    end

    // Test input filter
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            filt_cnt <= '0;
            test_flt <= 1'b1;
        end else if (lvl3_raw == test_flt) begin
            filt_cnt <= '0;
        end else if (filt_hit) begin
            filt_cnt <= '0;
            test_flt <= lvl3_raw;
        end else begin
            filt_cnt <= filt_cnt + 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            p2_q <= 1'b1;
            p3_q <= 1'b1;
            lvl <= 2'h2;
        end else begin
            p2_q <= p2_lvl;
            p3_q <= test_flt;
            lvl[1] <= test_flt;
            if (lvl2_upd) begin
                lvl[0] <= p2_lvl;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            fail_q <= 1'b0;
            blink_cnt <= '0;
            pwm_cnt <= '0;
        end else begin
            fail_q <= fail_on;
            if (!fail_on || fail_rise || blink_end) begin
                blink_cnt <= '0;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
            if (!fail_on || fail_rise || pwm_end) begin
                pwm_cnt <= '0;
            end else begin
                pwm_cnt <= pwm_cnt + 1'b1;
            end
        end
    end

    // Pin drivers, open drain for fail role
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            STATIC_FAIL_PIN_O <= 1'b0;
            STATIC_FAIL_PIN_OE_N <= 1'b1;
            BLINK_FAIL_PIN_O <= 1'b0;
            BLINK_FAIL_PIN_OE_N <= 1'b1;
            PULSED_FAIL_TEST_PIN_O <= 1'b0;
            PULSED_FAIL_TEST_PIN_OE_N <= 1'b1;
            TEST_LEVEL <= 1'b1;
        end else begin
            STATIC_FAIL_PIN_O <= 1'b0;
            STATIC_FAIL_PIN_OE_N <= ~fail_on;
            BLINK_FAIL_PIN_O <= drv2[0];
            BLINK_FAIL_PIN_OE_N <= drv2[1];
            PULSED_FAIL_TEST_PIN_O <= drv3[0];
            PULSED_FAIL_TEST_PIN_OE_N <= drv3[1];
            TEST_LEVEL <= test_flt;
        end
    end

    AST_RESET_ROLE: assert property (@(posedge MCLK) !NRST |=> ctrl == `FOG_CTRL_RST && duty == 2'h0)
        else $error("roles not fail output after reset");

    AST_CFG_FIXED: assert property (@(posedge MCLK) disable iff (!NRST)
        !is_normal |=> $stable(ctrl) && $stable(duty))
        else $error("config changed outside normal mode");

    AST_CFG_WRITE: assert property (@(posedge MCLK) disable iff (!NRST)
        cfg_wr && sel_ctrl |=> ctrl == $past(AVS_WRITEDATA[`FOG_CTRL_W-1:0]))
        else $error("control write lost");

    AST_WAKE_LATCH: assert property (@(posedge MCLK) disable iff (!NRST)
        (wake2 || wake3) |=> (stat & $past({wake3, wake2})) == $past({wake3, wake2}))
        else $error("wake event not latched");

    AST_WAKE_FS: assert property (@(posedge MCLK) disable iff (!NRST)
        SBC_MODE == fog_pkg::FOG_MODE_FAILSAFE |-> !wake2 && !wake3)
        else $error("wake in failsafe");

    AST_SW_OFF: assert property (@(posedge MCLK) disable iff (!NRST)
        (SBC_MODE == fog_pkg::FOG_MODE_RESTART || SBC_MODE == fog_pkg::FOG_MODE_FAILSAFE)
        && (role2 == fog_pkg::FOG_ROLE_LS || role2 == fog_pkg::FOG_ROLE_HS) |=> BLINK_FAIL_PIN_OE_N)
        else $error("switch driven in restart or failsafe");

    AST_FO_TOGETHER: assert property (@(posedge MCLK) disable iff (!NRST)
        fail_rise && role2 == fog_pkg::FOG_ROLE_FO && role3 == fog_pkg::FOG_ROLE_FO
        |=> !STATIC_FAIL_PIN_OE_N && !BLINK_FAIL_PIN_OE_N && !PULSED_FAIL_TEST_PIN_OE_N)
        else $error("fail outputs not asserted together");

    AST_PHASE_RESTART: assert property (@(posedge MCLK) disable iff (!NRST)
        fail_rise |=> blink_cnt == '0 && pwm_cnt == '0)
        else $error("waveform not restarted");

    AST_BLINK_HALF: assert property (@(posedge MCLK) disable iff (!NRST)
        fail_on && role2 == fog_pkg::FOG_ROLE_FO && blink_cnt == `FOG_BLINK_W'(BLINK_HALF - 1)
        |=> !BLINK_FAIL_PIN_OE_N ##1 BLINK_FAIL_PIN_OE_N)
        else $error("blink duty wrong");

    AST_PWM_DUTY: assert property (@(posedge MCLK) disable iff (!NRST)
        fail_on && duty == 2'h0 && pwm_cnt == `FOG_PWM_W'(PWM_CYC / 5 - 1) |-> pwm_low ##1 !pwm_low)
        else $error("pulsed duty wrong");

    AST_FILT: assert property (@(posedge MCLK) disable iff (!NRST)
        test_flt != $past(test_flt) |-> $past(filt_cnt) == `FOG_FILT_W'(`FOG_FILT_CYC - 1))
        else $error("test level accepted before filter time");

    AST_LVL_SHOW: assert property (@(posedge MCLK) disable iff (!NRST)
        lvl2_upd |=> lvl[0] == $past(p2_lvl) && lvl[1] == $past(test_flt))
        else $error("level status not updated");

endmodule : fog_fail_gpio

// ---- test/fog_pin_partner.sv ----
`timescale 1ns/10ps
module fog_pin_partner (
    input wire logic blink_o,
    input wire logic blink_oe_n,
    input wire logic pulsed_o,
    input wire logic pulsed_oe_n,
    input wire logic blink_src,
    input wire logic pulsed_src,
    output logic blink_lvl,
    output logic pulsed_lvl
);
    // Released pin shows the external source or load level
    assign blink_lvl = blink_oe_n ? blink_src : blink_o;
    assign pulsed_lvl = pulsed_oe_n ? pulsed_src : pulsed_o;
endmodule : fog_pin_partner

// ---- test/tb.sv ----
`timescale 1ns/10ps
`include "fog_defines.svh"
module tb;
    localparam int CYC = 200;
    logic mclk, nrst, avs_read, avs_write, fail_in, blink_src, pulsed_src;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata, nb, np;
    logic avs_waitrequest, static_o, static_oe_n, blink_o, blink_oe_n, pulsed_o, pulsed_oe_n;
    logic test_level, irq, blink_lvl, pulsed_lvl;
    fog_pkg::fog_mode_e sbc_mode;
    int failures, comparisons;

    fog_fail_gpio #(.BLINK_CYC(CYC), .PWM_CYC(CYC)) DUT (.MCLK(mclk), .NRST(nrst),
        .AVS_ADDRESS(avs_address), .AVS_BYTEENABLE(4'h1), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .SBC_MODE(sbc_mode), .FAIL_IN(fail_in), .STATIC_FAIL_PIN_O(static_o),
        .STATIC_FAIL_PIN_OE_N(static_oe_n), .BLINK_FAIL_PIN_I(blink_lvl), .BLINK_FAIL_PIN_O(blink_o),
        .BLINK_FAIL_PIN_OE_N(blink_oe_n), .PULSED_FAIL_TEST_PIN_I(pulsed_lvl),
        .PULSED_FAIL_TEST_PIN_O(pulsed_o), .PULSED_FAIL_TEST_PIN_OE_N(pulsed_oe_n),
        .TEST_LEVEL(test_level), .IRQ(irq));

    fog_pin_partner u_pins (.blink_o(blink_o), .blink_oe_n(blink_oe_n), .pulsed_o(pulsed_o),
        .pulsed_oe_n(pulsed_oe_n), .blink_src(blink_src), .pulsed_src(pulsed_src),
        .blink_lvl(blink_lvl), .pulsed_lvl(pulsed_lvl));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // Request held until the rising edge that samples waitrequest low; the watchdog ends a hang
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rdata, e);
    endtask : rd

    // Low cycles of both pins over one waveform period
    task automatic lows();
        nb = 32'h0;
        np = 32'h0;
        repeat (CYC) begin
            @(negedge mclk);
            nb = nb + {31'h0, ~blink_lvl};
            np = np + {31'h0, ~pulsed_lvl};
        end
    endtask : lows

    task automatic print_verdict();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(100 * 30000);
        failures++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        fail_in = 1'b0;
        sbc_mode = fog_pkg::FOG_MODE_NORMAL;
        blink_src = 1'b1;
        pulsed_src = 1'b1;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rd(`FOG_OFS_CTRL, 32'h0);
        rd(`FOG_OFS_DUTY, 32'h0);
        rd(`FOG_OFS_STAT, 32'h0);
        rd(`FOG_OFS_LVL, 32'h2);
        rd(5'h18, 32'h0);
        check(blink_oe_n, 1'b1);
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, `FOG_OFS_DUTY, d);
            bus(1'b1, `FOG_OFS_CTRL, 32'h40);
            cyc(3);
            check({static_o, static_oe_n}, 2'b00);
            check(blink_lvl, 1'b0);
            lows();
            check(nb, CYC / 2);
            check(np, (CYC / 5) >> d);
            bus(1'b1, `FOG_OFS_CTRL, 32'h0);
            cyc(3);
            check(static_oe_n, 1'b1);
        end
        bus(1'b1, `FOG_OFS_CTRL, 32'h49);
        cyc(3);
        check({static_oe_n, blink_oe_n, pulsed_oe_n}, 3'b011);
        bus(1'b1, `FOG_OFS_CTRL, 32'h0);
        @(posedge mclk) fail_in <= 1'b1;
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_RESTART;
        cyc(5);
        check(static_oe_n, 1'b0);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_NORMAL;
        cyc(3);
        check(static_oe_n, 1'b0);
        rd(`FOG_OFS_CTRL, 32'h0);
        @(posedge mclk) fail_in <= 1'b0;
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_STOP;
        bus(1'b1, `FOG_OFS_CTRL, 32'h23);
        rd(`FOG_OFS_CTRL, 32'h0);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_NORMAL;
        @(posedge mclk) pulsed_src <= 1'b0;
        bus(1'b1, `FOG_OFS_CTRL, 32'h23);
        rd(`FOG_OFS_CTRL, 32'h23);
        cyc(3);
        check({blink_lvl, pulsed_lvl}, 2'b01);
        rd(`FOG_OFS_LVL, 32'h2);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_SLEEP;
        cyc(3);
        check({blink_oe_n, pulsed_oe_n}, 2'b00);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_RESTART;
        cyc(3);
        check({blink_oe_n, pulsed_oe_n}, 2'b11);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_NORMAL;
        cyc(3);
        check({blink_lvl, pulsed_lvl}, 2'b01);
        rd(`FOG_OFS_CTRL, 32'h23);
        rd(`FOG_OFS_STAT, 32'h0);
        @(posedge mclk) pulsed_src <= 1'b1;
        bus(1'b1, `FOG_OFS_CTRL, 32'h12);
        bus(1'b1, `FOG_OFS_EN, 32'h3);
        bus(1'b1, `FOG_OFS_CLR, 32'h3);
        rd(`FOG_OFS_STAT, 32'h0);
        @(posedge mclk) blink_src <= 1'b0;
        cyc(3);
        check(irq, 1'b1);
        rd(`FOG_OFS_STAT, 32'h1);
        rd(`FOG_OFS_LVL, 32'h2);
        bus(1'b1, `FOG_OFS_CLR, 32'h1);
        cyc(2);
        check(irq, 1'b0);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_FAILSAFE;
        @(posedge mclk) blink_src <= 1'b1;
        cyc(3);
        rd(`FOG_OFS_STAT, 32'h0);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_RESTART;
        @(posedge mclk) blink_src <= 1'b0;
        cyc(3);
        rd(`FOG_OFS_STAT, 32'h1);
        bus(1'b1, `FOG_OFS_CLR, 32'h3);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_INIT;
        @(posedge mclk) blink_src <= 1'b1;
        @(posedge mclk) blink_src <= 1'b0;
        cyc(3);
        rd(`FOG_OFS_STAT, 32'h0);
        @(posedge mclk) sbc_mode <= fog_pkg::FOG_MODE_NORMAL;
        @(posedge mclk) pulsed_src <= 1'b0;
        cyc(600);
        check(test_level, 1'b1);
        cyc(60);
        check(test_level, 1'b0);
        rd(`FOG_OFS_LVL, 32'h0);
        rd(`FOG_OFS_STAT, 32'h2);
        print_verdict();
    end
endmodule : tb
